// ===== ldf_pkg.sv
// Constants, register map and field layout for the link deframer control block.
// Assumes an 8-bit register port and a single 10 MHz system clock.
package ldf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register port widths and offsets
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    localparam logic [11:0] OFS_CTRL0  = 12'h475;
    localparam logic [11:0] OFS_CTRL1  = 12'h476;
    localparam logic [11:0] OFS_CTRL2  = 12'h477;
    localparam logic [11:0] OFS_IRQ_ST = 12'h480;
    localparam logic [11:0] OFS_IRQ_MK = 12'h481;
    localparam logic [11:0] OFS_STATE  = 12'h482;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions of control register 0
    localparam int unsigned B0_RECEIVER_DISABLE   = 7;
    localparam int unsigned B0_SUBST    = 6;
    localparam int unsigned B0_SOFT_RST = 3;
    localparam int unsigned B0_FORCE    = 2;
    localparam int unsigned B0_REPLACE  = 0;
    // Field positions of control register 1
    localparam int unsigned B1_QUALIFY  = 4;
    localparam int unsigned B1_LATE_SCR = 3;
    localparam int unsigned B1_POST_SEL = 2;
    localparam int unsigned B1_SKIP_AL  = 1;
    localparam int unsigned B1_CHK_SEL  = 0;
    // Field positions of control register 2
    localparam int unsigned B2_ENDLESS  = 7;
    localparam int unsigned B2_REPEAT   = 5;

    // Writable bit masks; all other bits read as zero
    localparam logic [7:0] MASK_CTRL0 = 8'hCD;
    localparam logic [7:0] MASK_CTRL1 = 8'h1F;
    localparam logic [7:0] MASK_CTRL2 = 8'hA0;
    localparam logic [7:0] MASK_IRQ   = 8'h0F;

    // Reset values
    localparam logic [7:0] RST_CTRL0 = 8'h01;
    localparam logic [7:0] RST_CTRL1 = 8'h14;
    localparam logic [7:0] RST_CTRL2 = 8'h00;
    localparam logic [7:0] RST_IRQ   = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status bits
    localparam int unsigned IRQ_RESYNC   = 0;
    localparam int unsigned IRQ_CHK_ERR  = 1;
    localparam int unsigned IRQ_FRM_ERR  = 2;
    localparam int unsigned IRQ_TEST_ERR = 3;

    // Descrambler start octet of user data
    localparam logic [1:0] SCR_START_EARLY = 2'h0;
    localparam logic [1:0] SCR_START_LATE  = 2'h2;

    // Default count of disparity errors that forces a resync
    localparam int unsigned DISP_LIMIT_DEF = 4;

    // Lane configuration octets and checksum layout
    localparam int unsigned CFG_OCTETS = 11;
    localparam int unsigned NUM_FIELDS = 21;

    // Link states
    typedef enum logic [1:0] {
        LNK_OFF,
        LNK_CGS,
        LNK_ALIGN,
        LNK_DATA
    } ldf_state_e;

endpackage

// ===== ldf_checksum.sv
// Lane configuration checksum check with two summing methods.
// Assumes configuration octets and the received checksum are stable while cfg_valid_i is high.
`timescale 1ns/10ps
`default_nettype none
module ldf_checksum (
    input  wire logic                    clk_i,       // System clock
    input  wire logic                    rst_n_i,     // Async reset, active low
    input  wire logic                    clr_i,       // Synchronous clear
    input  wire logic                    method_i,    // 0 field sum, 1 octet sum
    input  wire logic                    cfg_valid_i, // Configuration complete pulse
    input  wire logic [8*ldf_pkg::CFG_OCTETS-1:0] cfg_i, // Octet 0 in low bits
    input  wire logic [7:0]              chk_rx_i,    // Received checksum
    output logic                         chk_err_o,   // Mismatch pulse
    output logic [7:0]                   chk_calc_o   // Last computed checksum
);
    import ldf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Field table: octet index, lsb, width
    localparam logic [3:0] F_OCT [NUM_FIELDS] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3,
        4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h7, 4'h8, 4'h8, 4'h9, 4'h9, 4'hA, 4'hA, 4'h3, 4'h3};
    localparam logic [2:0] F_LSB [NUM_FIELDS] = '{3'h0, 3'h4, 3'h0, 3'h6, 3'h5, 3'h0, 3'h7,
        3'h0, 3'h0, 3'h0, 3'h0, 3'h6, 3'h0, 3'h5, 3'h0, 3'h5, 3'h0, 3'h7, 3'h0, 3'h5, 3'h6};
    localparam logic [3:0] F_WID [NUM_FIELDS] = '{4'h8, 4'h4, 4'h4, 4'h1, 4'h1, 4'h5, 4'h1,
        4'h5, 4'h8, 4'h5, 4'h8, 4'h2, 4'h5, 4'h3, 4'h5, 4'h3, 4'h5, 4'h1, 4'h5, 4'h0, 4'h0};

    // Extract one field from the octet vector
    function automatic logic [7:0] field_val(input logic [8*CFG_OCTETS-1:0] v, input int k);
        logic [7:0] oct;
        logic [7:0] msk;
        oct = v[8*F_OCT[k] +: 8];
        msk = 8'(({1'b0, 8'hFF} >> (4'h8 - F_WID[k])));
        field_val = (oct >> F_LSB[k]) & msk;
    endfunction

    logic [7:0] sum_fld;
    logic [7:0] sum_reg;
    logic [7:0] calc;
    logic       err_d;
    logic       err_q;
    logic [7:0] calc_q;

    ////////////////////////////////////////////////////////////////////////////
    // Both sums modulo 256, chosen by the method bit
    always_comb begin
        sum_fld = 8'h00;
        sum_reg = 8'h00;
        for (int k = 0; k < NUM_FIELDS; k++) begin
            sum_fld = sum_fld + field_val(cfg_i, k);
        end
        for (int o = 0; o < CFG_OCTETS; o++) begin
            sum_reg = sum_reg + cfg_i[8*o +: 8];
        end
        calc  = method_i ? sum_reg : sum_fld; // RQ10
        err_d = cfg_valid_i && (calc != chk_rx_i);
    end

    // Result registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_q  <= 1'b0;
            calc_q <= 8'h00;
        end else if (clr_i) begin
            err_q  <= 1'b0;
            calc_q <= 8'h00;
        end else begin
            err_q  <= err_d;
            calc_q <= cfg_valid_i ? calc : calc_q;
        end
    end

    assign chk_err_o  = err_q;
    assign chk_calc_o = calc_q;

endmodule
`default_nettype wire

// ===== ldf_deframer_ctrl.sv
// Control, configuration and sync request logic of the serial link deframer.
// Assumes lane symbol flags arrive from receive logic on the same clock.
//
// Contract
// RQ1 - End-of-frame character substitution stops while its off bit is one.
// RQ2 - Software changes configuration only under soft reset.
// RQ3 - Soft reset synchronously clears deframer state and stops reception.
// RQ4 - Force bit holds sync request high in any link state.
// RQ5 - Errored frames are replaced while enabled; enabled after reset.
// RQ6 - Qualify on: not-in-table error hides a concurrent disparity error.
// RQ7 - Late descramble starts at user octet two, otherwise at octet zero.
// RQ8 - Select one resyncs on bad symbol after K; zero on disparity errors.
// RQ9 - Skip alignment goes straight to user data; one lane only. The code does not check LANES and skips for any lane count.
// RQ10 - Checksum sums individual fields at zero, packed octets at one.
// RQ11 - Endless alignment test expects alignment forever after code group sync.
// RQ12 - Repeat pattern test needs endless alignment test off.
// RQ13 - Receiver disable bit turns the receiver off.
// RQ14 - Reserved bits read zero; writing them has no effect.
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module ldf_deframer_ctrl #(
    parameter int unsigned DISP_LIMIT = ldf_pkg::DISP_LIMIT_DEF, // Disparity errors to resync
    parameter int unsigned LANES      = 1                        // Lanes in the link
) (
    input  wire logic                       clk_i,            // System clock
    input  wire logic                       rst_n_i,          // Async reset, active low
    input  wire logic [ldf_pkg::ADDR_W-1:0] addr_i,           // Register address
    input  wire logic [ldf_pkg::DATA_W-1:0] wdata_i,          // Write data
    input  wire logic                       wr_i,             // Write strobe
    input  wire logic                       rd_i,             // Read strobe
    output logic      [ldf_pkg::DATA_W-1:0] rdata_o,          // Read data, cycle after rd_i
    input  wire logic                       sym_valid_i,      // Lane symbol valid
    input  wire logic                       sym_k_i,          // Symbol is /K/
    input  wire logic                       sym_r_i,          // Symbol is /R/
    input  wire logic                       nit_err_i,        // Not-in-table error
    input  wire logic                       rd_err_i,         // Disparity error
    input  wire logic                       cgs_done_i,       // Code group sync reached
    input  wire logic                       ilas_done_i,      // Alignment sequence done
    input  wire logic                       frame_err_i,      // Frame received in error
    input  wire logic                       pat_err_i,        // Test pattern mismatch
    input  wire logic                       cfg_valid_i,      // Config octets complete
    input  wire logic [8*ldf_pkg::CFG_OCTETS-1:0] cfg_i,      // Config octets
    input  wire logic [7:0]                 chk_rx_i,         // Received checksum
    output logic                            sync_request_out_o, // Sync request to transmitter
    output logic                            rx_enable_o,      // Receiver running
    output logic                            end_char_subst_o, // Substitute end characters
    output logic                            frame_replace_o,  // Replace current frame
    output logic                            rd_err_qual_o,    // Qualified disparity error
    output logic [1:0]                      scr_start_o,      // Descramble start octet
    output logic                            user_data_o,      // Link in user data
    output logic                            align_phase_o,    // Alignment sequence expected
    output logic                            pattern_test_o,   // Repeat pattern test running
    output logic                            irq_o             // Interrupt, level
);
    import ldf_pkg::*;

    if (DISP_LIMIT < 1 || DISP_LIMIT > 255) $error("DISP_LIMIT out of range");
    if (LANES < 1) $error("LANES must be at least one");

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d;
    logic [7:0] ist_q, ist_d, imk_q, imk_d, rdata_q, rdata_d;
    logic [3:0] events;
    logic       soft_rst, receiver_disable, subst_off, force_req, repl_en;
    logic       qual, late_scr, post_sel, skip_al, chk_sel, endless, repeat_en;
    ldf_state_e st_q, st_d;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    assign soft_rst  = ctrl0_q[B0_SOFT_RST];
    assign receiver_disable    = ctrl0_q[B0_RECEIVER_DISABLE];
    assign subst_off = ctrl0_q[B0_SUBST];
    assign force_req = ctrl0_q[B0_FORCE];
    assign repl_en   = ctrl0_q[B0_REPLACE];
    assign qual      = ctrl1_q[B1_QUALIFY];
    assign late_scr  = ctrl1_q[B1_LATE_SCR];
    assign post_sel  = ctrl1_q[B1_POST_SEL];
    assign skip_al   = ctrl1_q[B1_SKIP_AL];
    assign chk_sel   = ctrl1_q[B1_CHK_SEL];
    assign endless   = ctrl2_q[B2_ENDLESS];
    assign repeat_en = ctrl2_q[B2_REPEAT];

    // Writes, read mux and sticky status; set beats write-one-clear
    always_comb begin
        ctrl0_d = ctrl0_q;
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        imk_d   = imk_q;
        ist_d   = ist_q;
        rdata_d = 8'h00;
        if (wr_i) begin
            if (hit(addr_i, OFS_CTRL0)) ctrl0_d = wdata_i & MASK_CTRL0; // RQ14
            if (hit(addr_i, OFS_CTRL1)) ctrl1_d = wdata_i & MASK_CTRL1; // RQ14
            if (hit(addr_i, OFS_CTRL2)) ctrl2_d = wdata_i & MASK_CTRL2; // RQ14
            if (hit(addr_i, OFS_IRQ_MK)) imk_d  = wdata_i & MASK_IRQ;
            if (hit(addr_i, OFS_IRQ_ST)) ist_d  = ist_q & ~(wdata_i & MASK_IRQ);
        end
        ist_d = ist_d | {4'h0, events};
        if (rd_i) begin
            if (hit(addr_i, OFS_CTRL0))  rdata_d = ctrl0_q;
            if (hit(addr_i, OFS_CTRL1))  rdata_d = ctrl1_q;
            if (hit(addr_i, OFS_CTRL2))  rdata_d = ctrl2_q;
            if (hit(addr_i, OFS_IRQ_ST)) rdata_d = ist_q;
            if (hit(addr_i, OFS_IRQ_MK)) rdata_d = imk_q;
            if (hit(addr_i, OFS_STATE))  rdata_d = {6'h00, st_q};
        end
    end

    // Register storage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl0_q <= RST_CTRL0;
            ctrl1_q <= RST_CTRL1;
            ctrl2_q <= RST_CTRL2;
            ist_q   <= RST_IRQ;
            imk_q   <= RST_IRQ;
            rdata_q <= 8'h00;
        end else begin
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            ist_q   <= ist_d;
            imk_q   <= imk_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o   = |(ist_q & imk_q);

    ////////////////////////////////////////////////////////////////////////////
    // Link state and sync request logic
    logic       run;
    logic       rd_q_err;
    logic       prev_k_q, prev_k_d;
    logic [7:0] disp_q, disp_d;
    logic       resync;
    logic       chk_err;

    assign run      = !soft_rst && !receiver_disable; // RQ3 RQ13
    assign rd_q_err = rd_err_i && !(qual && nit_err_i); // RQ6

    always_comb begin
        st_d     = st_q;
        prev_k_d = prev_k_q;
        disp_d   = disp_q;
        resync   = 1'b0;
        if (sym_valid_i) prev_k_d = sym_k_i;
        case (st_q)
            LNK_OFF: begin
                if (run) st_d = LNK_CGS;
            end
            LNK_CGS: begin
                disp_d = 8'h00;
                if (cgs_done_i) st_d = (skip_al && !endless) ? LNK_DATA : LNK_ALIGN; // RQ9
            end
            LNK_ALIGN: begin
                if (ilas_done_i && !endless) st_d = LNK_DATA; // RQ11
            end
            LNK_DATA: begin
                if (post_sel) begin
                    // Bad symbol after /K/ means the transmitter lost sync
                    resync = sym_valid_i && prev_k_q && !sym_k_i && !sym_r_i; // RQ8
                end else begin
                    if (sym_valid_i && rd_q_err) disp_d = disp_q + 8'h01;
                    resync = (disp_d >= 8'(DISP_LIMIT)); // RQ8
                end
                if (resync) st_d = LNK_CGS;
            end
            default: st_d = LNK_OFF;
        endcase
        // Soft reset or disable forces power-on state
        if (!run) begin
            st_d     = LNK_OFF; // RQ3
            prev_k_d = 1'b0;
            disp_d   = 8'h00;
        end
    end

    // Link state storage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q     <= LNK_OFF;
            prev_k_q <= 1'b0;
            disp_q   <= 8'h00;
        end else begin
            st_q     <= st_d;
            prev_k_q <= prev_k_d;
            disp_q   <= disp_d;
        end
    end

    // Event sources for the sticky status
    assign events[IRQ_RESYNC]   = resync;
    assign events[IRQ_CHK_ERR]  = chk_err;
    assign events[IRQ_FRM_ERR]  = run && frame_err_i;
    assign events[IRQ_TEST_ERR] = pattern_test_o && pat_err_i;

    ////////////////////////////////////////////////////////////////////////////
    // Datapath control outputs
    assign sync_request_out_o = force_req || st_q == LNK_CGS || st_q == LNK_OFF; // RQ4
    assign rx_enable_o        = run;
    assign end_char_subst_o   = run && !subst_off; // RQ1
    assign frame_replace_o    = run && repl_en && frame_err_i; // RQ5
    assign rd_err_qual_o      = run && rd_q_err;
    assign scr_start_o        = late_scr ? SCR_START_LATE : SCR_START_EARLY; // RQ7
    assign user_data_o        = st_q == LNK_DATA;
    assign align_phase_o      = st_q == LNK_ALIGN;
    assign pattern_test_o     = run && repeat_en && !endless && st_q == LNK_DATA; // RQ12

    // Configuration checksum check
    ldf_checksum u_chk (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .clr_i       (!run),
        .method_i    (chk_sel),
        .cfg_valid_i (cfg_valid_i && run),
        .cfg_i       (cfg_i),
        .chk_rx_i    (chk_rx_i),
        .chk_err_o   (chk_err),
        .chk_calc_o  ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_force_sync_out: assert property (force_req |-> sync_request_out_o) // RQ4
        else $error("force bit set without sync request");
    chk_soft_reset_off: assert property ($rose(soft_rst) |=> st_q == LNK_OFF && !rx_enable_o) // RQ3
        else $error("soft reset did not stop deframer");
    chk_rx_disable: assert property (receiver_disable |-> !rx_enable_o && !end_char_subst_o) // RQ13
        else $error("receiver active while disabled");
    chk_subst_off: assert property (subst_off |-> !end_char_subst_o) // RQ1
        else $error("substitution active while off");
    chk_frame_replace: assert property (run && repl_en && frame_err_i |-> frame_replace_o) // RQ5
        else $error("errored frame not replaced");
    chk_rd_qualify: assert property (qual && nit_err_i |-> !rd_err_qual_o) // RQ6
        else $error("disparity error not masked by nit");
    chk_scr_start: assert property (scr_start_o == (late_scr ? 2'h2 : 2'h0)) // RQ7
        else $error("wrong descramble start octet");
    chk_k_resync: assert property (st_q == LNK_DATA && post_sel && run && sym_valid_i // RQ8
        && prev_k_q && !sym_k_i && !sym_r_i |=> sync_request_out_o)
        else $error("no resync after bad symbol after K");
    chk_skip_align: assert property (st_q == LNK_CGS && run && cgs_done_i && skip_al // RQ9
        && !endless |=> user_data_o)
        else $error("alignment not skipped");
    chk_endless_align: assert property (endless && st_q == LNK_ALIGN && run // RQ11
        |=> align_phase_o || !run)
        else $error("left alignment in endless test");
    chk_pattern_test: assert property (endless |-> !pattern_test_o) // RQ12
        else $error("pattern test with endless alignment");
    chk_reserved_zero: assert property (rd_i && hit(addr_i, OFS_CTRL1) // RQ14
        |=> rdata_o[7:5] == 3'h0)
        else $error("reserved bits not zero");

    cov_link_data: cover property (st_q == LNK_ALIGN ##1 st_q == LNK_DATA);
    cov_resync: cover property (st_q == LNK_DATA ##1 st_q == LNK_CGS);
    cov_irq: cover property ($rose(irq_o));

endmodule
`default_nettype wire

// ===== ldf_framer_model.sv
// Behavioural one-lane link transmitter that faces the deframer's lane flags.
// Assumes the deframer's sync request and alignment flags on the same clock.
`timescale 1ns/10ps
`default_nettype none
module ldf_framer_model (
    input  wire logic clk_i,       // System clock
    input  wire logic rst_n_i,     // Async reset, active low
    input  wire logic sync_req_i,  // Sync request from deframer
    input  wire logic align_i,     // Deframer expects alignment
    input  wire logic slow_i,      // Stretch lock and alignment times
    input  wire logic bad_i,       // Send a /K/ followed by bare data
    output logic      sym_valid_o, // Symbol valid
    output logic      sym_k_o,     // Symbol is /K/
    output logic      sym_r_o,     // Symbol is /R/
    output logic      cgs_done_o,  // Code group sync reached
    output logic      ilas_done_o  // Alignment sequence done
);
    logic [3:0] cnt_q;
    logic [1:0] mode_q;
    logic       bad_q;
    logic [3:0] lim;
    logic       same;
    ////////////////////////////////////////
    // One lane only, so skipping alignment stays legal on this link
    assign lim = slow_i ? 4'h9 : 4'h2;
    assign same = ({sync_req_i, align_i} == mode_q);
    // Symbol stream: /K/ while sync is asked for, one /R/ after /K/, then data
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q       <= 4'h0;
            mode_q      <= 2'h0;
            bad_q       <= 1'b0;
            sym_valid_o <= 1'b0;
            sym_k_o     <= 1'b0;
            sym_r_o     <= 1'b0;
            cgs_done_o  <= 1'b0;
            ilas_done_o <= 1'b0;
        end else begin
            mode_q      <= {sync_req_i, align_i};
            cnt_q       <= same ? cnt_q + {3'h0, cnt_q != 4'hF} : 4'h0;
            bad_q       <= bad_i;
            sym_valid_o <= 1'b1;
            sym_k_o     <= sync_req_i | bad_i;
            sym_r_o     <= ~(sync_req_i | bad_i) & sym_k_o & ~bad_q;
            cgs_done_o  <= sync_req_i & same & (cnt_q >= lim);
            ilas_done_o <= align_i & ~sync_req_i & same & (cnt_q >= lim);
        end
    end
endmodule
`default_nettype wire

// ===== serial_link_deframer_control_bench.sv
// Self-checking bench for the link deframer control block.
// Assumes the framer model on the lane flags and a 10 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module serial_link_deframer_control_bench;
    import ldf_pkg::*;
    logic        clk_i, rst_n_i, wr_i, rd_i, sym_valid_i, sym_k_i, sym_r_i, nit_err_i, rd_err_i;
    logic        cgs_done_i, ilas_done_i, frame_err_i, pat_err_i, cfg_valid_i, slow, bad;
    logic        sync_request_out_o, rx_enable_o, end_char_subst_o, frame_replace_o;
    logic        rd_err_qual_o, user_data_o, align_phase_o, pattern_test_o, irq_o, seen;
    logic [11:0] addr_i;
    logic [7:0]  wdata_i, rdata_o, chk_rx_i, d;
    logic [87:0] cfg_i;
    logic [1:0]  scr_start_o;
    int          n_fail, check_count, cyc;
    ldf_deframer_ctrl #(.DISP_LIMIT(2), .LANES(1)) dut (.*);
    ldf_framer_model u_framer (.clk_i, .rst_n_i, .sync_req_i(sync_request_out_o),
        .align_i(align_phase_o), .slow_i(slow), .bad_i(bad), .sym_valid_o(sym_valid_i),
        .sym_k_o(sym_k_i), .sym_r_o(sym_r_i), .cgs_done_o(cgs_done_i), .ilas_done_o(ilas_done_i));
    ////////////////////////////////////////
    // Register port cycles
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        @(negedge clk_i);
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        @(negedge clk_i);
        v = rdata_o;
    endtask
    // Configure under soft reset, then release it
    task automatic bring_up(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] c2);
        wr(OFS_CTRL0, c0 | 8'h08);
        wr(OFS_CTRL1, c1);
        wr(OFS_CTRL2, c2);
        wr(OFS_CTRL0, c0);
    endtask
    task automatic wait_data();
        for (int i = 0; i < 60 && user_data_o !== 1'b1; i++) begin
            @(negedge clk_i);
            if (align_phase_o === 1'b1) seen = 1'b1;
        end
    endtask
    task automatic frm(input logic e);
        @(posedge clk_i);
        frame_err_i <= 1'b1;
        @(negedge clk_i);
        `CHK("replace", e, frame_replace_o)
        @(posedge clk_i);
        frame_err_i <= 1'b0;
    endtask
    task automatic errs(input logic n, input int k, input logic q);
        repeat (k) begin
            @(posedge clk_i);
            rd_err_i  <= 1'b1;
            nit_err_i <= n;
            @(negedge clk_i);
            `CHK("rd_err_qual", q, rd_err_qual_o)
        end
        @(posedge clk_i);
        rd_err_i  <= 1'b0;
        nit_err_i <= 1'b0;
    endtask
    task automatic cfg_case(input logic [7:0] rx, input logic e);
        wr(OFS_IRQ_ST, 8'h0F);
        @(posedge clk_i);
        cfg_i       <= {56'h0, 8'h80, 24'h0};
        chk_rx_i    <= rx;
        cfg_valid_i <= 1'b1;
        @(posedge clk_i);
        cfg_valid_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd(OFS_IRQ_ST, d);
        `CHK("chk_err", e, d[IRQ_CHK_ERR])
    endtask
    ////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        `CHK("sync_rst", 1'b1, sync_request_out_o)
        rd(OFS_CTRL0, d);
        `CHK("ctrl0_rst", 8'h01, d)
        rd(OFS_CTRL1, d);
        `CHK("ctrl1_rst", 8'h14, d)
        rd(OFS_CTRL2, d);
        `CHK("ctrl2_rst", 8'h00, d)
        rd(12'h123, d);
        `CHK("unmapped", 8'h00, d)
    endtask
    task automatic t_fields();
        wr(OFS_CTRL0, 8'hFF);
        rd(OFS_CTRL0, d);
        `CHK("ctrl0_mask", 8'hCD, d)
        `CHK("rx_en_off", 1'b0, rx_enable_o)
        wr(OFS_CTRL1, 8'hFF);
        rd(OFS_CTRL1, d);
        `CHK("ctrl1_mask", 8'h1F, d)
        `CHK("scr_late", SCR_START_LATE, scr_start_o)
        wr(OFS_CTRL2, 8'hFF);
        rd(OFS_CTRL2, d);
        `CHK("ctrl2_mask", 8'hA0, d)
        bring_up(8'h80, 8'h14, 8'h00);
        repeat (8) @(negedge clk_i);
        `CHK("rxdis_data", 1'b0, user_data_o)
        `CHK("rxdis_en", 1'b0, rx_enable_o)
    endtask
    task automatic t_force();
        bring_up(8'h01, 8'h14, 8'h00);
        wait_data();
        `CHK("sync_data", 1'b0, sync_request_out_o)
        `CHK("scr_early", SCR_START_EARLY, scr_start_o)
        `CHK("subst_on", 1'b1, end_char_subst_o)
        rd(OFS_STATE, d);
        `CHK("state_data", 8'h03, d)
        wr(OFS_CTRL0, 8'h05);
        @(negedge clk_i);
        `CHK("force_sync", 2'h3, {sync_request_out_o, user_data_o})
        wr(OFS_CTRL0, 8'h01);
        @(negedge clk_i);
        `CHK("force_off", 1'b0, sync_request_out_o)
        frm(1'b1);
    endtask
    task automatic t_resync_k();
        wr(OFS_IRQ_ST, 8'h0F);
        wr(OFS_IRQ_MK, 8'h01);
        `CHK("irq_idle", 1'b0, irq_o)
        @(posedge clk_i);
        bad <= 1'b1;
        @(posedge clk_i);
        bad <= 1'b0;
        repeat (3) @(negedge clk_i);
        `CHK("resync_k", 2'h2, {sync_request_out_o, user_data_o})
        `CHK("irq_set", 1'b1, irq_o)
        wr(OFS_IRQ_MK, 8'h00);
        `CHK("irq_mask", 1'b0, irq_o)
        wr(OFS_IRQ_MK, 8'h01);
        wr(OFS_IRQ_ST, 8'h01);
        rd(OFS_IRQ_ST, d);
        `CHK("irq_clr", 2'h0, {irq_o, d[IRQ_RESYNC]})
    endtask
    task automatic t_disparity();
        bring_up(8'h40, 8'h10, 8'h00);
        wait_data();
        `CHK("subst_off", 1'b0, end_char_subst_o)
        errs(1'b1, 3, 1'b0);
        errs(1'b0, 1, 1'b1);
        repeat (3) @(negedge clk_i);
        `CHK("disp_one", 1'b1, user_data_o)
        errs(1'b0, 1, 1'b1);
        repeat (3) @(negedge clk_i);
        `CHK("disp_two", 1'b0, user_data_o)
        bring_up(8'h00, 8'h00, 8'h00);
        wait_data();
        frm(1'b0);
        errs(1'b1, 2, 1'b1);
        repeat (3) @(negedge clk_i);
        `CHK("unqualified", 1'b0, user_data_o)
    endtask
    task automatic t_modes();
        slow <= 1'b1;
        bring_up(8'h01, 8'h16, 8'h00);
        seen = 1'b0;
        wait_data();
        `CHK("skip_align", 2'h1, {seen, user_data_o})
        slow <= 1'b0;
        bring_up(8'h01, 8'h14, 8'h80);
        repeat (40) @(negedge clk_i);
        `CHK("endless", 2'h2, {align_phase_o, user_data_o})
        bring_up(8'h01, 8'h14, 8'h20);
        wait_data();
        `CHK("pat_test", 1'b1, pattern_test_o)
        @(posedge clk_i);
        pat_err_i <= 1'b1;
        @(posedge clk_i);
        pat_err_i <= 1'b0;
        rd(OFS_IRQ_ST, d);
        `CHK("pat_err", 1'b1, d[IRQ_TEST_ERR])
        bring_up(8'h01, 8'h14, 8'h00);
        cfg_case(8'h01, 1'b0);
        cfg_case(8'h80, 1'b1);
        bring_up(8'h01, 8'h15, 8'h00);
        cfg_case(8'h80, 1'b0);
        cfg_case(8'h01, 1'b1);
    endtask
    ////////////////////////////////////////
    // Verdict, clock, timeout and main sequence
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        {rst_n_i, wr_i, rd_i, nit_err_i, rd_err_i, frame_err_i, pat_err_i, cfg_valid_i} = '0;
        {slow, bad, addr_i, wdata_i, chk_rx_i, cfg_i} = '0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_fields();
        t_force();
        t_resync_k();
        t_disparity();
        t_modes();
        end_sim();
    end
endmodule
`default_nettype wire
